// ### dcs_pkg.sv
// Package of offsets, limits and codes for the drive control special registers
`default_nettype none
package dcs_pkg;
    // ==========================================
    // Register offsets (device numbers, decimal)
    localparam logic [10:0] A_LOOP2_MEAS = 11'd1223;
    localparam logic [10:0] A_EN_C_LO = 11'd1224;
    localparam logic [10:0] A_EN_C_HI = 11'd1225;
    localparam logic [10:0] A_EN_F_LO = 11'd1226;
    localparam logic [10:0] A_EN_F_HI = 11'd1227;
    localparam logic [10:0] A_NET_RX = 11'd1228;
    localparam logic [10:0] A_TRACE = 11'd1229;
    localparam logic [10:0] A_TURNS = 11'd1230;
    localparam logic [10:0] A_CAL_RAM = 11'd1234;
    localparam logic [10:0] A_CAL_NVM = 11'd1235;
    localparam logic [10:0] A_PSAMPLE = 11'd1236;
    localparam logic [10:0] A_PTOT_LO = 11'd1237;
    localparam logic [10:0] A_PTOT_HI = 11'd1238;
    localparam logic [10:0] A_PCLEAR = 11'd1239;
    localparam logic [10:0] A_PRUN = 11'd1240;
    localparam logic [10:0] A_PIDX_RAM = 11'd1241;
    localparam logic [10:0] A_PVAL_RAM = 11'd1242;
    localparam logic [10:0] A_PIDX_NVM = 11'd1243;
    localparam logic [10:0] A_PVAL_NVM = 11'd1244;
    localparam logic [10:0] A_AIN1 = 11'd1245;
    localparam logic [10:0] A_AIN2 = 11'd1246;
    localparam logic [10:0] A_AIN4 = 11'd1247;
    localparam logic [10:0] A_SETPOINT = 11'd1248;
    localparam logic [10:0] A_MEASURED = 11'd1249;
    localparam logic [10:0] A_LOOP_OUT = 11'd1250;
    localparam logic [10:0] A_METER = 11'd1251;
    localparam logic [10:0] A_AMETER = 11'd1252;
    localparam logic [10:0] A_OPT0 = 11'd1253;
    localparam logic [10:0] A_OPT1 = 11'd1254;
    // ==========================================
    // Limits, codes and reset values
    localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;         // 32767
    localparam logic [26:0] TOTAL_MAX = 27'd99999999;
    localparam logic [15:0] SRC_FROM_REG = 16'h0046;       // Selector value 70
    localparam logic [15:0] CLEAR_CMD = 16'h0001;
    localparam logic [1:0] CAL_FREQ = 2'h0;
    localparam logic [1:0] CAL_PARAM = 2'h1;
    localparam logic [1:0] CAL_TERM = 2'h2;
    localparam logic [15:0] WORD_RST = 16'h0000;
endpackage
`default_nettype wire

// ### dcs_sreg.sv
// Special register bank: pulse counter, parameter access, loop and analog words
//
// Operation
// - Sample count per cycle, capped at 32767
// - Cumulative total up to 99999999 over two words
// - Clear request clears counts, self-returns to zero
// - Count only while run register holds 1
// - RAM content follows selected RAM parameter index
// - Non-volatile pair works like RAM pair
// - Analog inputs 1, 2, 4 readable separately
// - Manipulated amount readable in its register
// - Meter terminal from register when selector 70
// - Analog meter from register when selector 70
// - Option output zero when either selector 70
// - Option output one when either selector 70
// - Second loop measured value always updated
// - Energy words split low/high, two resolutions
`default_nettype none
module dcs_sreg
    import dcs_pkg::*;
#(
    parameter int IDX_W = 8                      // Parameter index bits used to address the stores
) (
    input wire logic sys_clk,                    // 125 MHz clock
    input wire logic sys_rst,                    // Sync reset, high
    input wire logic [10:0] reg_addr,            // Register device number
    input wire logic reg_wr,                     // Write strobe
    input wire logic [15:0] reg_wdata,           // Write data
    output logic [15:0] reg_rdata_r,             // Read data, one cycle later
    input wire logic pulse_in,                   // One-cycle strobe per pulse
    input wire logic count_tick,                 // End of count cycle
    input wire logic [15:0] ain_one,             // Terminal 1 input
    input wire logic [15:0] ain_two,             // Terminal 2 input
    input wire logic [15:0] ain_four,            // Terminal 4 input
    input wire logic [15:0] loop_out_in,         // Manipulated amount
    input wire logic [15:0] loop2_meas_in,       // Second loop measured value
    input wire logic [31:0] energy_coarse_in,    // Energy, 1kWh units
    input wire logic [31:0] energy_fine_in,      // Energy, fine units
    input wire logic [15:0] net_rx_in,           // Network receive status
    input wire logic [15:0] trace_in,            // Trace state
    input wire logic [15:0] turns_in,            // Encoder turn count
    input wire logic [15:0] meter_out_source_select,     // Meter source
    input wire logic [15:0] analog_meter_source_select,  // Analog meter source
    input wire logic [15:0] option_out_source_select_a,  // Option source a
    input wire logic [15:0] option_out_source_select_b,  // Option source b
    input wire logic [15:0] meter_int_in,        // Meter internal value
    input wire logic [15:0] ameter_int_in,       // Analog meter internal value
    input wire logic [15:0] opt0_int_in,         // Option out 0 internal value
    input wire logic [15:0] opt1_int_in,         // Option out 1 internal value
    output logic [15:0] loop_setpoint_r,         // Set point to the loop
    output logic [15:0] loop_measured_r,         // Measured value to the loop
    output logic [15:0] meter_output_terminal_r, // Meter terminal drive
    output logic [15:0] analog_meter_terminal_r, // Analog meter drive
    output logic [15:0] option_analog_out_zero_r, // Option output 0 drive
    output logic [15:0] option_analog_out_one_r  // Option output 1 drive
);
    localparam int MEM_D = 4 << IDX_W;
    localparam int MEM_W = IDX_W + 2;

    // ==========================================
    // Pulse counter state
    logic [15:0] cyc_cnt_r, cyc_cnt_nxt;
    logic [15:0] sample_r, sample_nxt;
    logic [26:0] total_r, total_nxt;
    logic clear_r, clear_nxt;
    logic run_r, run_nxt;
    logic [27:0] total_sum;
    logic wr_clear;

    // Clear register write decoded once; command value checked where used
    assign wr_clear = reg_wr && (reg_addr == A_PCLEAR);

    // Counting, sampling and accumulation
    always_comb begin
        cyc_cnt_nxt = cyc_cnt_r;
        sample_nxt = sample_r;
        total_nxt = total_r;
        clear_nxt = clear_r;
        run_nxt = run_r;
        total_sum = '0;
        if (reg_wr && reg_addr == A_PRUN) begin
            run_nxt = reg_wdata[0];
        end
        if (clear_r) begin
            // Request served: counts zeroed, flag drops by itself
            cyc_cnt_nxt = WORD_RST;
            sample_nxt = WORD_RST;
            total_nxt = '0;
            clear_nxt = 1'b0;
        end else if (run_r) begin
            if (count_tick) begin
                // Pulse landing on the tick is part of the closing cycle
                if (pulse_in && cyc_cnt_r < SAMPLE_MAX) begin
                    sample_nxt = cyc_cnt_r + 16'h0001;
                end else begin
                    sample_nxt = cyc_cnt_r;
                end
                // Saturate rather than wrap so software never sees a drop
                total_sum = {1'b0, total_r} + {12'h000, sample_nxt};
                if (total_sum > {1'b0, TOTAL_MAX}) begin
                    total_nxt = TOTAL_MAX;
                end else begin
                    total_nxt = total_sum[26:0];
                end
                cyc_cnt_nxt = WORD_RST;
            end else if (pulse_in && cyc_cnt_r < SAMPLE_MAX) begin
                cyc_cnt_nxt = cyc_cnt_r + 16'h0001;
            end
        end
        // A new request written in the serving cycle is kept
        if (wr_clear && reg_wdata == CLEAR_CMD) begin
            clear_nxt = 1'b1;
        end
    end

    // Pulse counter registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cyc_cnt_r <= WORD_RST;
            sample_r <= WORD_RST;
            total_r <= '0;
            clear_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            cyc_cnt_r <= cyc_cnt_nxt;
            sample_r <= sample_nxt;
            total_r <= total_nxt;
            clear_r <= clear_nxt;
            run_r <= run_nxt;
        end
    end

    // ==========================================
    // Parameter access state
    logic [15:0] idx_ram_r, idx_ram_nxt;
    logic [15:0] idx_nvm_r, idx_nvm_nxt;
    logic [15:0] cal_ram_r, cal_ram_nxt;
    logic [15:0] cal_nvm_r, cal_nvm_nxt;
    logic [15:0] ram_mem [MEM_D];
    logic [15:0] nvm_mem [MEM_D];
    logic [MEM_W-1:0] ram_sel, nvm_sel;
    logic ram_we, nvm_we;

    // Calibration target widens the index so each target has its own slot
    assign ram_sel = {cal_ram_r[1:0], idx_ram_r[IDX_W-1:0]};
    assign nvm_sel = {cal_nvm_r[1:0], idx_nvm_r[IDX_W-1:0]};
    assign ram_we = reg_wr && (reg_addr == A_PVAL_RAM);
    assign nvm_we = reg_wr && (reg_addr == A_PVAL_NVM);

    // Index and selector writes
    always_comb begin
        idx_ram_nxt = idx_ram_r;
        idx_nvm_nxt = idx_nvm_r;
        cal_ram_nxt = cal_ram_r;
        cal_nvm_nxt = cal_nvm_r;
        if (reg_wr) begin
            case (reg_addr)
                A_PIDX_RAM: idx_ram_nxt = reg_wdata;
                A_PIDX_NVM: idx_nvm_nxt = reg_wdata;
                A_CAL_RAM: cal_ram_nxt = reg_wdata;
                A_CAL_NVM: cal_nvm_nxt = reg_wdata;
                default: idx_ram_nxt = idx_ram_r;
            endcase
        end
    end

    // Index registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            idx_ram_r <= WORD_RST;
            idx_nvm_r <= WORD_RST;
            cal_ram_r <= {14'h0000, CAL_FREQ};
            cal_nvm_r <= {14'h0000, CAL_FREQ};
        end else begin
            idx_ram_r <= idx_ram_nxt;
            idx_nvm_r <= idx_nvm_nxt;
            cal_ram_r <= cal_ram_nxt;
            cal_nvm_r <= cal_nvm_nxt;
        end
    end

    // Parameter stores; content is undefined until first written
    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram_mem[ram_sel] <= reg_wdata;
        end
        if (nvm_we) begin
            nvm_mem[nvm_sel] <= reg_wdata;
        end
    end

    // ==========================================
    // Loop and analog output words
    logic [15:0] sp_nxt, meas_nxt;
    logic [15:0] meter_val_r, meter_val_nxt;
    logic [15:0] ameter_val_r, ameter_val_nxt;
    logic [15:0] opt0_val_r, opt0_val_nxt;
    logic [15:0] opt1_val_r, opt1_val_nxt;
    logic [15:0] meter_drv_nxt, ameter_drv_nxt, opt0_drv_nxt, opt1_drv_nxt;
    logic opt_any_sel;

    // Either option selector hands both option outputs to the registers
    assign opt_any_sel = (option_out_source_select_a == SRC_FROM_REG) ||
                         (option_out_source_select_b == SRC_FROM_REG);

    // Software words and terminal source choice
    always_comb begin
        sp_nxt = loop_setpoint_r;
        meas_nxt = loop_measured_r;
        meter_val_nxt = meter_val_r;
        ameter_val_nxt = ameter_val_r;
        opt0_val_nxt = opt0_val_r;
        opt1_val_nxt = opt1_val_r;
        if (reg_wr) begin
            case (reg_addr)
                A_SETPOINT: sp_nxt = reg_wdata;
                A_MEASURED: meas_nxt = reg_wdata;
                A_METER: meter_val_nxt = reg_wdata;
                A_AMETER: ameter_val_nxt = reg_wdata;
                A_OPT0: opt0_val_nxt = reg_wdata;
                A_OPT1: opt1_val_nxt = reg_wdata;
                default: sp_nxt = loop_setpoint_r;
            endcase
        end
        if (meter_out_source_select == SRC_FROM_REG) begin
            meter_drv_nxt = meter_val_nxt;
        end else begin
            meter_drv_nxt = meter_int_in;
        end
        if (analog_meter_source_select == SRC_FROM_REG) begin
            ameter_drv_nxt = ameter_val_nxt;
        end else begin
            ameter_drv_nxt = ameter_int_in;
        end
        if (opt_any_sel) begin
            opt0_drv_nxt = opt0_val_nxt;
            opt1_drv_nxt = opt1_val_nxt;
        end else begin
            opt0_drv_nxt = opt0_int_in;
            opt1_drv_nxt = opt1_int_in;
        end
    end

    // Loop and output registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            loop_setpoint_r <= WORD_RST;
            loop_measured_r <= WORD_RST;
            meter_val_r <= WORD_RST;
            ameter_val_r <= WORD_RST;
            opt0_val_r <= WORD_RST;
            opt1_val_r <= WORD_RST;
            meter_output_terminal_r <= WORD_RST;
            analog_meter_terminal_r <= WORD_RST;
            option_analog_out_zero_r <= WORD_RST;
            option_analog_out_one_r <= WORD_RST;
        end else begin
            loop_setpoint_r <= sp_nxt;
            loop_measured_r <= meas_nxt;
            meter_val_r <= meter_val_nxt;
            ameter_val_r <= ameter_val_nxt;
            opt0_val_r <= opt0_val_nxt;
            opt1_val_r <= opt1_val_nxt;
            meter_output_terminal_r <= meter_drv_nxt;
            analog_meter_terminal_r <= ameter_drv_nxt;
            option_analog_out_zero_r <= opt0_drv_nxt;
            option_analog_out_one_r <= opt1_drv_nxt;
        end
    end

    // ==========================================
    // Monitor snapshots
    logic [15:0] ain1_r, ain2_r, ain4_r, lout_r, l2m_r;
    logic [15:0] rx_r, trace_r, turns_r;
    logic [31:0] en_c_r, en_f_r;

    // Monitors sampled every cycle; both energy halves share one edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ain1_r <= WORD_RST;
            ain2_r <= WORD_RST;
            ain4_r <= WORD_RST;
            lout_r <= WORD_RST;
            l2m_r <= WORD_RST;
            rx_r <= WORD_RST;
            trace_r <= WORD_RST;
            turns_r <= WORD_RST;
            en_c_r <= '0;
            en_f_r <= '0;
        end else begin
            ain1_r <= ain_one;
            ain2_r <= ain_two;
            ain4_r <= ain_four;
            lout_r <= loop_out_in;
            l2m_r <= loop2_meas_in;
            rx_r <= net_rx_in;
            trace_r <= trace_in;
            turns_r <= turns_in;
            en_c_r <= energy_coarse_in;
            en_f_r <= energy_fine_in;
        end
    end

    // ==========================================
    // Read path
    logic [15:0] rd_nxt;

    // Read mux; unmapped numbers return zero
    always_comb begin
        case (reg_addr)
            A_LOOP2_MEAS: rd_nxt = l2m_r;
            A_EN_C_LO: rd_nxt = en_c_r[15:0];
            A_EN_C_HI: rd_nxt = en_c_r[31:16];
            A_EN_F_LO: rd_nxt = en_f_r[15:0];
            A_EN_F_HI: rd_nxt = en_f_r[31:16];
            A_NET_RX: rd_nxt = rx_r;
            A_TRACE: rd_nxt = trace_r;
            A_TURNS: rd_nxt = turns_r;
            A_CAL_RAM: rd_nxt = cal_ram_r;
            A_CAL_NVM: rd_nxt = cal_nvm_r;
            A_PSAMPLE: rd_nxt = sample_r;
            A_PTOT_LO: rd_nxt = total_r[15:0];
            A_PTOT_HI: rd_nxt = {5'h00, total_r[26:16]};
            A_PCLEAR: rd_nxt = {15'h0000, clear_r};
            A_PRUN: rd_nxt = {15'h0000, run_r};
            A_PIDX_RAM: rd_nxt = idx_ram_r;
            A_PVAL_RAM: rd_nxt = ram_mem[ram_sel];
            A_PIDX_NVM: rd_nxt = idx_nvm_r;
            A_PVAL_NVM: rd_nxt = nvm_mem[nvm_sel];
            A_AIN1: rd_nxt = ain1_r;
            A_AIN2: rd_nxt = ain2_r;
            A_AIN4: rd_nxt = ain4_r;
            A_SETPOINT: rd_nxt = loop_setpoint_r;
            A_MEASURED: rd_nxt = loop_measured_r;
            A_LOOP_OUT: rd_nxt = lout_r;
            A_METER: rd_nxt = meter_val_r;
            A_AMETER: rd_nxt = ameter_val_r;
            A_OPT0: rd_nxt = opt0_val_r;
            A_OPT1: rd_nxt = opt1_val_r;
            default: rd_nxt = WORD_RST;
        endcase
    end

    // Registered read data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_r <= WORD_RST;
        end else begin
            reg_rdata_r <= rd_nxt;
        end
    end

endmodule
`default_nettype wire

// ### dcs_sreg_properties.sv
// Port-level checker for the special register bank
`default_nettype none
module dcs_sreg_props
    import dcs_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic [10:0] reg_addr, // Register number
    input wire logic reg_wr, // Write strobe
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic [15:0] reg_rdata_r, // Read data
    input wire logic count_tick, // Count cycle end
    input wire logic [15:0] ain_one, // Terminal 1 input
    input wire logic [15:0] meter_out_source_select, // Meter source
    input wire logic [15:0] analog_meter_source_select, // Analog meter source
    input wire logic [15:0] option_out_source_select_a, // Option source a
    input wire logic [15:0] option_out_source_select_b, // Option source b
    input wire logic [15:0] meter_int_in, // Meter internal
    input wire logic [15:0] ameter_int_in, // Analog meter internal
    input wire logic [15:0] opt0_int_in, // Option 0 internal
    input wire logic [15:0] loop_setpoint_r, // Set point word
    input wire logic [15:0] meter_output_terminal_r, // Meter drive
    input wire logic [15:0] analog_meter_terminal_r, // Analog meter drive
    input wire logic [15:0] option_analog_out_zero_r, // Option 0 drive
    input wire logic [15:0] option_analog_out_one_r // Option 1 drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Shared clocking and the steps of a clear
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence clr_req;
        reg_wr && reg_addr == A_PCLEAR && reg_wdata == CLEAR_CMD;
    endsequence
    // No writes or ticks, so nothing can refill the counts meanwhile
    sequence quiet;
        !reg_wr && !count_tick;
    endsequence
    // ==========================================
    // Counter clear, reads and software words
    clear_self_a: assert property (
        clr_req ##1 quiet [*3] ##0 reg_addr == A_PCLEAR |=> reg_rdata_r == WORD_RST)
        else $error("clear request did not fall back to zero");
    clear_counts_a: assert property (
        clr_req ##1 quiet [*4] ##0 reg_addr == A_PSAMPLE |=> reg_rdata_r == WORD_RST)
        else $error("sample count not cleared");
    ain_read_a: assert property (
        (reg_addr == A_AIN1 && $stable(ain_one)) [*3] |-> reg_rdata_r == ain_one)
        else $error("terminal 1 word does not follow its input");
    setpoint_hold_a: assert property (
        (reg_wr && reg_addr == A_SETPOINT) ##1 !reg_wr [*2] |->
        loop_setpoint_r == $past(reg_wdata, 2))
        else $error("set point word lost");
    // ==========================================
    // Terminal source selection
    meter_pass_a: assert property (
        meter_out_source_select != SRC_FROM_REG |=> meter_output_terminal_r == $past(meter_int_in))
        else $error("meter terminal not on its internal source");
    ameter_pass_a: assert property (
        (analog_meter_source_select != SRC_FROM_REG) [*2] |->
        analog_meter_terminal_r == $past(ameter_int_in))
        else $error("analog meter terminal not on its internal source");
    opt0_pass_a: assert property (
        option_out_source_select_a != SRC_FROM_REG && option_out_source_select_b != SRC_FROM_REG
        |=> option_analog_out_zero_r == $past(opt0_int_in))
        else $error("option output zero not on its internal source");
    opt1_reg_a: assert property (
        reg_wr && reg_addr == A_OPT1 && option_out_source_select_b == SRC_FROM_REG
        |=> option_analog_out_one_r == $past(reg_wdata))
        else $error("option output one not driven from its register");
endmodule
bind dcs_sreg dcs_sreg_props u_props (.*);
`default_nettype wire

// ### tb.sv
// Self-checking bench for the special register bank
`default_nettype none
module tb
    import dcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Design signals and bookkeeping
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] reg_addr;
    logic reg_wr, pulse_in, count_tick;
    logic [15:0] reg_wdata, reg_rdata_r, ain_one, ain_two, ain_four, loop_out_in;
    logic [15:0] loop2_meas_in, net_rx_in, trace_in, turns_in, meter_int_in, ameter_int_in;
    logic [31:0] energy_coarse_in, energy_fine_in;
    logic [15:0] opt0_int_in, opt1_int_in, loop_setpoint_r, loop_measured_r;
    logic [15:0] meter_out_source_select, analog_meter_source_select;
    logic [15:0] option_out_source_select_a, option_out_source_select_b;
    logic [15:0] meter_output_terminal_r, analog_meter_terminal_r;
    logic [15:0] option_analog_out_zero_r, option_analog_out_one_r;
    logic [31:0] seed = 32'h0000_94c1;
    int fails = 0;
    int checked = 0;
    // Last entry is an unmapped number between the monitors and calibration
    logic [10:0] ro_list [13] = '{A_LOOP2_MEAS, A_EN_C_LO, A_EN_C_HI, A_EN_F_LO, A_EN_F_HI,
        A_NET_RX, A_TRACE, A_TURNS, A_AIN1, A_AIN2, A_AIN4, A_LOOP_OUT, 11'h4cf};
    logic [10:0] rw_list [6] = '{A_SETPOINT, A_MEASURED, A_METER, A_AMETER, A_OPT0, A_OPT1};

    dcs_sreg DUT (.*);

    // Free-running 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    // ==========================================
    // Expectation helpers and drivers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] cap(input int n);
        return (n > 32767) ? SAMPLE_MAX : 16'(n);
    endfunction
    function automatic logic [15:0] pick(input logic [15:0] s1, s2, rv, iv);
        return (s1 == SRC_FROM_REG || s2 == SRC_FROM_REG) ? rv : iv;
    endfunction
    function automatic logic [15:0] ro_exp(input logic [10:0] a);
        case (a)
            A_LOOP2_MEAS: return loop2_meas_in;
            A_EN_C_LO: return energy_coarse_in[15:0];
            A_EN_C_HI: return energy_coarse_in[31:16];
            A_EN_F_LO: return energy_fine_in[15:0];
            A_EN_F_HI: return energy_fine_in[31:16];
            A_NET_RX: return net_rx_in;
            A_TRACE: return trace_in;
            A_TURNS: return turns_in;
            A_AIN1: return ain_one;
            A_AIN2: return ain_two;
            A_AIN4: return ain_four;
            A_LOOP_OUT: return loop_out_in;
            default: return WORD_RST;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Idle cycle after each write keeps the strobe from toggling twice at once
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rchk(input logic [10:0] a, input logic [15:0] e);
        reg_addr = a;
        @(posedge sys_clk);
        #1 chk(reg_rdata_r, e);
    endtask
    // Last pulse lands on the tick edge, so it must count in the closing cycle
    task automatic pulses(input int n);
        pulse_in = (n > 0);
        repeat ((n > 1) ? n - 1 : 0) @(posedge sys_clk);
        #1 count_tick = 1'b1;
        @(posedge sys_clk);
        #1 pulse_in = 1'b0;
        count_tick = 1'b0;
    endtask
    task automatic cnt_chk(input logic [15:0] s, input int t);
        rchk(A_PSAMPLE, s);
        rchk(A_PTOT_LO, t[15:0]);
        rchk(A_PTOT_HI, t[31:16]);
    endtask
    task automatic rnd_inputs();
        {ain_one, ain_two} = xs();
        {ain_four, loop_out_in} = xs();
        {loop2_meas_in, net_rx_in} = xs();
        {trace_in, turns_in} = xs();
        {meter_int_in, ameter_int_in} = xs();
        {opt0_int_in, opt1_int_in} = xs();
        energy_coarse_in = xs();
        energy_fine_in = xs();
    endtask
    task automatic print_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] rw_val [6];
        logic [15:0] pv [3];
        logic [15:0] s [4];
        logic [15:0] smp;
        logic [10:0] ca, ia, va;
        int n;
        int tot;
        reg_addr = A_PRUN;
        reg_wr = 1'b0;
        reg_wdata = WORD_RST;
        pulse_in = 1'b0;
        count_tick = 1'b0;
        meter_out_source_select = WORD_RST;
        analog_meter_source_select = WORD_RST;
        option_out_source_select_a = WORD_RST;
        option_out_source_select_b = SRC_FROM_REG;
        rnd_inputs();
        repeat (5) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        // Read-only words, a refused write and an unmapped number
        wr(A_AIN1, ~ain_one);
        rchk(A_AIN1, ain_one);
        for (int k = 0; k < 3; k++) begin
            rnd_inputs();
            repeat (2) @(posedge sys_clk);
            #1;
            foreach (ro_list[i]) rchk(ro_list[i], ro_exp(ro_list[i]));
        end
        // Writable words read back and reach the loop
        foreach (rw_list[i]) begin
            rw_val[i] = 16'(xs());
            wr(rw_list[i], rw_val[i]);
            rchk(rw_list[i], rw_val[i]);
        end
        chk(loop_setpoint_r, rw_val[0]);
        chk(loop_measured_r, rw_val[1]);
        // Selectors: all at 70, none, 71 next to the code, then random
        for (int k = 0; k < 8; k++) begin
            r = xs();
            rnd_inputs();
            foreach (s[j]) s[j] = (k == 0 || (r[j] && k > 2)) ? SRC_FROM_REG :
                (k == 2) ? 16'h0047 : {8'h00, r[8*j+:8]};
            meter_out_source_select = s[0];
            analog_meter_source_select = s[1];
            option_out_source_select_a = s[2];
            option_out_source_select_b = s[3];
            @(posedge sys_clk);
            #1 chk(meter_output_terminal_r, pick(s[0], s[0], rw_val[2], meter_int_in));
            chk(analog_meter_terminal_r, pick(s[1], s[1], rw_val[3], ameter_int_in));
            chk(option_analog_out_zero_r, pick(s[2], s[3], rw_val[4], opt0_int_in));
            chk(option_analog_out_one_r, pick(s[2], s[3], rw_val[5], opt1_int_in));
        end
        // Parameter pairs, one value per calibration target, neighbour index disturbed
        r = xs();
        for (int m = 0; m < 2; m++) begin
            ca = m ? A_CAL_NVM : A_CAL_RAM;
            ia = m ? A_PIDX_NVM : A_PIDX_RAM;
            va = m ? A_PVAL_NVM : A_PVAL_RAM;
            for (int c = 0; c < 3; c++) begin
                pv[c] = 16'(xs());
                wr(ca, 16'(c));
                wr(ia, {8'h00, r[7:0]});
                wr(va, pv[c]);
            end
            wr(ia, {8'h00, r[7:0] + 8'h01});
            wr(va, ~pv[2]);
            for (int c = 0; c < 3; c++) begin
                wr(ca, 16'(c));
                rchk(ca, 16'(c));
                wr(ia, {8'h00, r[7:0]});
                rchk(va, pv[c]);
            end
        end
        // Pulse counter: cap, high word carry, stop, refused clear, restart
        tot = 0;
        smp = WORD_RST;
        wr(A_PCLEAR, CLEAR_CMD);
        wr(A_PRUN, 16'h0001);
        for (int k = 0; k < 7; k++) begin
            r = xs();
            n = (k < 2) ? 32770 : (k == 2) ? 0 : int'(r[3:0] | 4'h2);
            if (k == 3) wr(A_PRUN, WORD_RST);
            if (k == 3) rchk(A_PRUN, WORD_RST);
            if (k == 4) wr(A_PCLEAR, 16'h0002);
            if (k == 5) wr(A_PRUN, 16'h0001);
            pulses(n);
            if (k != 3 && k != 4) smp = cap(n);
            if (k != 3 && k != 4) tot = tot + int'(smp);
            cnt_chk(smp, tot);
        end
        wr(A_PCLEAR, CLEAR_CMD);
        rchk(A_PCLEAR, WORD_RST);
        rchk(A_PCLEAR, WORD_RST);
        cnt_chk(WORD_RST, 0);
        print_verdict();
    end

    // Watchdog well past the expected run of about 66000 cycles
    initial begin
        #800_000;
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
